// file: hdl/banked_core_register_file.sv
// Banked core register file with mode and status state, APB debug view.
// Assumes decode/execute/exception logic on CLOCK drives ports synchronously.
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module banked_core_register_file
    import core_regs_pkg::*;
(
    input wire logic CLOCK,
    input wire logic ARST_N,
    input wire logic CLK_EN,
    input wire logic [3:0] RD_A_NUM,
    input wire logic [3:0] RD_B_NUM,
    output logic [31:0] RD_A_DATA,
    output logic [31:0] RD_B_DATA,
    input wire logic WR_EN,
    input wire logic [3:0] WR_NUM,
    input wire logic [31:0] WR_DATA,
    input wire logic CALL_EN,
    input wire logic [31:0] CALL_RETURN,
    input wire logic EXC_EN,
    input wire core_regs_pkg::mode_t EXC_MODE,
    input wire logic [31:0] EXC_RETURN,
    input wire logic [31:0] EXC_VECTOR,
    input wire logic EXC_RETURN_EN,
    input wire logic STATUS_WR_EN,
    input wire logic [31:0] STATUS_WR_DATA,
    input wire logic PC_LOAD_EN,
    input wire logic [31:0] PC_LOAD,
    input wire logic ADV,
    input wire logic XFER_EN,
    input wire core_regs_pkg::size_t_t XFER_SIZE,
    input wire logic [1:0] XFER_ADDR,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic [31:0] STATUS,
    output logic PRIVILEGED,
    output logic COMPACT,
    output core_regs_pkg::stage_t STAGE,
    output logic MISALIGNED
);
    import core_regs_pkg::*;

    logic [31:0] phys [0:NUM_PHYS-1];
    logic [31:0] saved [0:NUM_SAVED-1];
    logic [31:0] status;
    stage_t stage;
    stage_t next_stage;
    mode_t mode;
    logic [2:0] saved_idx;
    logic saved_ok;
    logic apb_wr;
    logic apb_rd;
    logic apb_gpr;
    logic [4:0] apb_phys;
    logic [4:0] wr_phys;
    logic core_wr;
    logic [4:0] exc_link_phys;
    logic [2:0] exc_saved_idx;
    logic [31:0] restored;
    logic [3:0] cur_saved;
    logic [3:0] exc_saved;
    mode_t exc_target;
    logic [7:0] gpr_off;

    // Legal mode code or fall back to user, so a bad write cannot escape banking
    function automatic mode_t legal_mode(input logic [4:0] m);
        case (m)
            MODE_USER, MODE_FAST, MODE_IRQ, MODE_SVC,
            MODE_ABORT, MODE_UNDEF, MODE_SYSTEM: legal_mode = mode_t'(m);
            default: legal_mode = MODE_USER;
        endcase
    endfunction : legal_mode

    function automatic logic [4:0] sp_base(input mode_t m);
        case (m)
            MODE_FAST: sp_base = PHYS_FAST_SP;
            MODE_IRQ: sp_base = PHYS_IRQ_SP;
            MODE_SVC: sp_base = PHYS_SVC_SP;
            MODE_ABORT: sp_base = PHYS_ABORT_SP;
            MODE_UNDEF: sp_base = PHYS_UNDEF_SP;
            default: sp_base = {1'b0, REG_STACK};
        endcase
    endfunction : sp_base

    function automatic logic [4:0] map_phys(input mode_t m, input logic [3:0] n);
        if (n <= REG_LAST_SHARED)
            map_phys = {1'b0, n};
        else if (n == REG_PC)
            map_phys = PHYS_PC;
        else if (n <= REG_FAST_LAST)
            map_phys = (m == MODE_FAST) ?
                PHYS_FAST_BASE + {1'b0, n - REG_FAST_FIRST} : {1'b0, n};
        else
            map_phys = sp_base(m) + {4'h0, n == REG_LINK};
    endfunction : map_phys

    // Saved word slot; user and system own none
    function automatic logic [3:0] saved_of(input mode_t m);
        case (m)
            MODE_FAST: saved_of = 4'h8;
            MODE_IRQ: saved_of = 4'h9;
            MODE_SVC: saved_of = 4'hA;
            MODE_ABORT: saved_of = 4'hB;
            MODE_UNDEF: saved_of = 4'hC;
            default: saved_of = 4'h0;
        endcase
    endfunction : saved_of

    assign mode = legal_mode(status[4:0]);
    assign cur_saved = saved_of(mode);
    assign saved_idx = cur_saved[2:0];
    assign saved_ok = cur_saved[3];
    // A user target would leave the handler unprivileged, so it lands in supervisor
    assign exc_target = (legal_mode(EXC_MODE) == MODE_USER) ? MODE_SVC : legal_mode(EXC_MODE);
    assign exc_link_phys = sp_base(exc_target) + 5'h01;
    assign exc_saved = saved_of(exc_target);
    assign exc_saved_idx = exc_saved[2:0];
    // Restore legalises the mode too, so a stale saved word cannot escape banking
    assign restored = saved_ok ?
        {saved[saved_idx][31:5] & SW_MASK[31:5], legal_mode(saved[saved_idx][4:0])} : status;
    assign apb_wr = PSEL && PENABLE && PWRITE && PREADY;
    assign apb_rd = PSEL && !PENABLE && !PWRITE;
    assign gpr_off = PADDR - ADDR_GPR_BASE;
    assign apb_gpr = PADDR >= ADDR_GPR_BASE && !gpr_off[7];
    assign apb_phys = gpr_off[6:2];
    assign wr_phys = map_phys(mode, WR_NUM);
    // Writes land only as the write stage retires
    assign core_wr = WR_EN && stage == STG_WRITE && ADV;

    always_comb
    begin
        case (stage)
            STG_FETCH: next_stage = STG_DECODE;
            STG_DECODE: next_stage = STG_EXECUTE;
            STG_EXECUTE: next_stage = STG_MEMORY;
            STG_MEMORY: next_stage = STG_WRITE;
            STG_WRITE: next_stage = STG_FETCH;
            default: next_stage = STG_FETCH;
        endcase
    end

    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
            stage <= STG_FETCH;
        else if (CLK_EN && ADV)
            stage <= next_stage;
    end

    // Physical registers; exception and call writes win over plain writeback
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PHYS; gi++)
        begin : g_phys
            always_ff @(posedge CLOCK or negedge ARST_N)
            begin
                if (!ARST_N)
                    phys[gi] <= (gi == PHYS_PC) ? RESET_PC : 32'h00000000;
                else if (CLK_EN)
                begin
                    if (EXC_EN && gi == exc_link_phys)
                        phys[gi] <= EXC_RETURN;
                    else if (EXC_EN && gi == PHYS_PC)
                        phys[gi] <= EXC_VECTOR;
                    else if (EXC_RETURN_EN && gi == PHYS_PC)
                        phys[gi] <= phys[map_phys(mode, REG_LINK)];
                    else if (CALL_EN && gi == map_phys(mode, REG_LINK))
                        phys[gi] <= CALL_RETURN;
                    else if (PC_LOAD_EN && gi == PHYS_PC)
                        phys[gi] <= PC_LOAD;
                    else if (core_wr && gi == wr_phys)
                        phys[gi] <= WR_DATA;
                    else if (apb_wr && apb_gpr && gi == apb_phys)
                        phys[gi] <= PWDATA;
                end
            end
        end
        for (gi = 0; gi < NUM_SAVED; gi++)
        begin : g_saved
            always_ff @(posedge CLOCK or negedge ARST_N)
            begin
                if (!ARST_N)
                    saved[gi] <= 32'h00000000;
                else if (CLK_EN)
                begin
                    if (EXC_EN && exc_saved[3] && gi == exc_saved_idx)
                        saved[gi] <= status;
                    else if (apb_wr && PADDR == ADDR_SAVED && saved_ok && gi == saved_idx)
                        saved[gi] <= PWDATA & SW_MASK;
                end
            end
        end
    endgenerate

    // Exception entry forces a privileged mode and masks IRQ; fast interrupts are masked only on fast entry
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
            status <= SW_RESET;
        else if (CLK_EN)
        begin
            if (EXC_EN)
            begin
                status[4:0] <= exc_target;
                status[SW_IRQ_DIS] <= 1'b1;
                status[SW_FAST_DIS] <= status[SW_FAST_DIS] || exc_target == MODE_FAST;
                status[SW_COMPACT] <= 1'b0;
            end
            else if (EXC_RETURN_EN)
                status <= restored;
            else if (STATUS_WR_EN)
                status <= {STATUS_WR_DATA[31:5] & SW_MASK[31:5],
                    legal_mode(STATUS_WR_DATA[4:0])};
            else if (apb_wr && PADDR == ADDR_STATUS)
                status <= {PWDATA[31:5] & SW_MASK[31:5], legal_mode(PWDATA[4:0])};
        end
    end

    // Register read ports; pc port sees the live program counter
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            RD_A_DATA <= 32'h00000000;
            RD_B_DATA <= 32'h00000000;
        end
        else if (CLK_EN)
        begin
            RD_A_DATA <= phys[map_phys(mode, RD_A_NUM)];
            RD_B_DATA <= phys[map_phys(mode, RD_B_NUM)];
        end
    end

    // Alignment check; byte never misaligns
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
            MISALIGNED <= 1'b0;
        else if (CLK_EN)
            MISALIGNED <= XFER_EN && ((XFER_SIZE == SIZE_WORD && XFER_ADDR != 2'b00) ||
                (XFER_SIZE == SIZE_HALF && XFER_ADDR[0]));
    end

    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            STATUS <= SW_RESET;
            PRIVILEGED <= 1'b1;
            COMPACT <= 1'b0;
            STAGE <= STG_FETCH;
        end
        else if (CLK_EN)
        begin
            STATUS <= status;
            PRIVILEGED <= mode != MODE_USER;
            COMPACT <= status[SW_COMPACT];
            STAGE <= ADV ? next_stage : stage;
        end
    end

    // APB: no wait states, read data ready at access phase
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h00000000;
        end
        else if (CLK_EN)
        begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !apb_gpr && PADDR > ADDR_INFO;
            if (apb_rd)
            begin
                if (apb_gpr)
                    PRDATA <= (apb_phys < NUM_PHYS) ? phys[apb_phys] : 32'h00000000;
                else
                    case (PADDR)
                        ADDR_STATUS: PRDATA <= status;
                        ADDR_SAVED: PRDATA <= saved_ok ? saved[saved_idx] : 32'h00000000;
                        ADDR_PC: PRDATA <= phys[PHYS_PC];
                        ADDR_INFO: PRDATA <= {29'h0, stage};
                        default: PRDATA <= 32'h00000000;
                    endcase
            end
        end
    end
endmodule : banked_core_register_file
`default_nettype wire

// file: hdl/core_regs_pkg.sv
// Constants and types for the banked core register file.
// Assumes a single core clock domain and an APB register port.
package core_regs_pkg;
    typedef enum logic [4:0]
    {
        MODE_USER = 5'h10,
        MODE_FAST = 5'h11,
        MODE_IRQ = 5'h12,
        MODE_SVC = 5'h13,
        MODE_ABORT = 5'h17,
        MODE_UNDEF = 5'h1B,
        MODE_SYSTEM = 5'h1F
    } mode_t;
    typedef enum logic [2:0]
    {
        STG_FETCH = 3'h0,
        STG_DECODE = 3'h1,
        STG_EXECUTE = 3'h2,
        STG_MEMORY = 3'h3,
        STG_WRITE = 3'h4
    } stage_t;
    typedef enum logic [1:0]
    {
        SIZE_BYTE = 2'h0,
        SIZE_HALF = 2'h1,
        SIZE_WORD = 2'h2
    } size_t_t;
    localparam int NUM_PHYS = 31;
    localparam int PHYS_AW = 5;
    localparam int DATA_W = 32;
    localparam int NUM_SAVED = 5;
    localparam logic [3:0] REG_STACK = 4'hD;
    localparam logic [3:0] REG_LINK = 4'hE;
    localparam logic [3:0] REG_PC = 4'hF;
    localparam logic [3:0] REG_LAST_SHARED = 4'h7;
    localparam logic [3:0] REG_FAST_FIRST = 4'h8;
    localparam logic [3:0] REG_FAST_LAST = 4'hC;
    // Physical slots: 0..14 user, 15 pc, 16..20 fast 8..12, then 13/14 pairs
    localparam logic [4:0] PHYS_PC = 5'h0F;
    localparam logic [4:0] PHYS_FAST_BASE = 5'h10;
    localparam logic [4:0] PHYS_FAST_SP = 5'h15;
    localparam logic [4:0] PHYS_IRQ_SP = 5'h17;
    localparam logic [4:0] PHYS_SVC_SP = 5'h19;
    localparam logic [4:0] PHYS_ABORT_SP = 5'h1B;
    localparam logic [4:0] PHYS_UNDEF_SP = 5'h1D;
    // Status word field positions
    localparam int SW_N = 31;
    localparam int SW_Z = 30;
    localparam int SW_C = 29;
    localparam int SW_V = 28;
    localparam int SW_IRQ_DIS = 7;
    localparam int SW_FAST_DIS = 6;
    localparam int SW_COMPACT = 5;
    localparam logic [31:0] SW_MASK = 32'hF00000FF;
    localparam logic [31:0] SW_RESET = 32'h000000D3;
    // APB map
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_SAVED = 8'h04;
    localparam logic [7:0] ADDR_PC = 8'h08;
    localparam logic [7:0] ADDR_INFO = 8'h0C;
    localparam logic [7:0] ADDR_GPR_BASE = 8'h40;
    localparam logic [31:0] RESET_PC = 32'h00000000;
endpackage : core_regs_pkg

// file: verif/core_pipe_model.sv
// Model of the core decode and execute side: pipeline advance only.
// Assumes the core clock; slow makes it advance every other cycle.
`timescale 1ns/1ps
`default_nettype none
module core_pipe_model
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic slow,
    output logic adv
);
    // Stalls stretch each stage, so writes must still wait for the last one
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            adv <= 1'b0;
        else
            adv <= slow ? ~adv : 1'b1;
    end
endmodule : core_pipe_model
`default_nettype wire

// file: verif/core_regs_assertions.sv
// Checker for the banked core register file, bound to its ports.
// Assumes one core clock and the async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module core_regs_checker
    import core_regs_pkg::*;
(
    input wire logic CLOCK,
    input wire logic ARST_N,
    input wire logic CLK_EN,
    input wire logic ADV,
    input wire logic EXC_EN,
    input wire logic EXC_RETURN_EN,
    input wire logic STATUS_WR_EN,
    input wire logic [31:0] STATUS_WR_DATA,
    input wire logic XFER_EN,
    input wire core_regs_pkg::size_t_t XFER_SIZE,
    input wire logic [1:0] XFER_ADDR,
    input wire logic [31:0] STATUS,
    input wire logic PRIVILEGED,
    input wire logic COMPACT,
    input wire core_regs_pkg::stage_t STAGE,
    input wire logic MISALIGNED
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!ARST_N);
    AST_STAGE_STEP: assert property (CLK_EN && ADV && STAGE != STG_WRITE |=>
        STAGE == $past(STAGE) + 3'h1) else $error("stage did not step by one");
    AST_STAGE_WRAP: assert property (CLK_EN && ADV && STAGE == STG_WRITE |=>
        STAGE == STG_FETCH) else $error("stage did not wrap to fetch");
    AST_STAGE_HOLD: assert property (!(CLK_EN && ADV) |=> $stable(STAGE))
        else $error("stage moved without advance");
    AST_PRIV: assert property (PRIVILEGED == (STATUS[4:0] != MODE_USER))
        else $error("privilege flag wrong for mode");
    AST_COMPACT: assert property (COMPACT == STATUS[SW_COMPACT])
        else $error("compact flag differs from status");
    AST_MASK: assert property ((STATUS & ~SW_MASK) == 32'h0)
        else $error("status has bits outside its fields");
    AST_EXC_ENTRY: assert property (CLK_EN && EXC_EN |-> ##[1:2]
        STATUS[4:0] != MODE_USER && STATUS[SW_IRQ_DIS] && !COMPACT)
        else $error("exception entry state wrong");
    AST_SW_MODE: assert property (CLK_EN && STATUS_WR_EN && !EXC_EN && !EXC_RETURN_EN &&
        STATUS_WR_DATA[4:0] == MODE_FAST |-> ##[1:2] STATUS[4:0] == MODE_FAST)
        else $error("software mode write lost");
    AST_MIS_WORD: assert property (CLK_EN && XFER_EN && XFER_SIZE == SIZE_WORD &&
        XFER_ADDR != 2'h0 |=> MISALIGNED) else $error("odd word not flagged");
    AST_MIS_BYTE: assert property (CLK_EN && XFER_EN && XFER_SIZE == SIZE_BYTE |=>
        !MISALIGNED) else $error("byte flagged misaligned");
    cover property (CLK_EN && EXC_EN);
    cover property (CLK_EN && EXC_RETURN_EN);
    cover property (MISALIGNED);
endmodule : core_regs_checker
bind banked_core_register_file core_regs_checker core_regs_checker_i (
    .CLOCK(CLOCK), .ARST_N(ARST_N), .CLK_EN(CLK_EN), .ADV(ADV), .EXC_EN(EXC_EN),
    .EXC_RETURN_EN(EXC_RETURN_EN), .STATUS_WR_EN(STATUS_WR_EN),
    .STATUS_WR_DATA(STATUS_WR_DATA), .XFER_EN(XFER_EN), .XFER_SIZE(XFER_SIZE),
    .XFER_ADDR(XFER_ADDR), .STATUS(STATUS), .PRIVILEGED(PRIVILEGED), .COMPACT(COMPACT),
    .STAGE(STAGE), .MISALIGNED(MISALIGNED));
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the banked core register file.
// Assumes the pipeline model drives advance; the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import core_regs_pkg::*;
    logic CLOCK, ARST_N, CLK_EN, WR_EN, CALL_EN, EXC_EN, EXC_RETURN_EN, STATUS_WR_EN;
    logic PC_LOAD_EN, ADV, XFER_EN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, PRIVILEGED;
    logic COMPACT, MISALIGNED, slow, err;
    logic [3:0] RD_A_NUM, RD_B_NUM, WR_NUM;
    logic [1:0] XFER_ADDR;
    logic [7:0] PADDR;
    logic [31:0] RD_A_DATA, RD_B_DATA, WR_DATA, CALL_RETURN, EXC_RETURN, EXC_VECTOR;
    logic [31:0] STATUS_WR_DATA, PC_LOAD, PWDATA, PRDATA, STATUS, v;
    mode_t EXC_MODE;
    size_t_t XFER_SIZE;
    stage_t STAGE;
    logic [31:0] exp_q[$];
    int error_cnt, checked, seed, i;
    mode_t modes[7] = '{MODE_USER, MODE_FAST, MODE_IRQ, MODE_SVC, MODE_ABORT, MODE_UNDEF,
        MODE_SYSTEM};
    logic [4:0] sp_slot[7] = '{5'h0D, PHYS_FAST_SP, PHYS_IRQ_SP, PHYS_SVC_SP, PHYS_ABORT_SP,
        PHYS_UNDEF_SP, 5'h0D};
    banked_core_register_file banked_core_register_file_i (
        .CLOCK(CLOCK), .ARST_N(ARST_N), .CLK_EN(CLK_EN), .RD_A_NUM(RD_A_NUM),
        .RD_B_NUM(RD_B_NUM), .RD_A_DATA(RD_A_DATA), .RD_B_DATA(RD_B_DATA), .WR_EN(WR_EN),
        .WR_NUM(WR_NUM), .WR_DATA(WR_DATA), .CALL_EN(CALL_EN), .CALL_RETURN(CALL_RETURN),
        .EXC_EN(EXC_EN), .EXC_MODE(EXC_MODE), .EXC_RETURN(EXC_RETURN), .EXC_VECTOR(EXC_VECTOR),
        .EXC_RETURN_EN(EXC_RETURN_EN), .STATUS_WR_EN(STATUS_WR_EN),
        .STATUS_WR_DATA(STATUS_WR_DATA), .PC_LOAD_EN(PC_LOAD_EN), .PC_LOAD(PC_LOAD), .ADV(ADV),
        .XFER_EN(XFER_EN), .XFER_SIZE(XFER_SIZE), .XFER_ADDR(XFER_ADDR), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .STATUS(STATUS), .PRIVILEGED(PRIVILEGED),
        .COMPACT(COMPACT), .STAGE(STAGE), .MISALIGNED(MISALIGNED));
    core_pipe_model core_pipe_model_i (.clock(CLOCK), .arst_n(ARST_N), .slow(slow), .adv(ADV));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic e);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        do @(posedge CLOCK); while (!PREADY);
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLOCK);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0, err);
    endtask : rd
    task automatic set_sw(input logic [31:0] d);
        STATUS_WR_EN <= 1'b1;
        STATUS_WR_DATA <= d;
        @(posedge CLOCK);
        STATUS_WR_EN <= 1'b0;
        repeat (2) @(posedge CLOCK);
    endtask : set_sw
    // Held until the write stage, so an early write would show as a stray value
    task automatic wb(input logic [3:0] n, input logic [31:0] d);
        WR_EN <= 1'b1;
        WR_NUM <= n;
        WR_DATA <= d;
        do @(posedge CLOCK); while (!(STAGE == STG_WRITE && ADV));
        WR_EN <= 1'b0;
    endtask : wb
    task automatic hit(input logic [3:0] k);
        {CALL_EN, EXC_EN, EXC_RETURN_EN, PC_LOAD_EN} <= k;
        @(posedge CLOCK);
        {CALL_EN, EXC_EN, EXC_RETURN_EN, PC_LOAD_EN} <= 4'h0;
        repeat (2) @(posedge CLOCK);
    endtask : hit
    always @(posedge CLOCK)
    begin
        if (PSEL && PENABLE && PREADY && !PWRITE)
            chk(PRDATA, exp_q.pop_front());
    end
    initial
    begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end
    initial
    begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end
    initial
    begin
        seed = 27652;
        {ARST_N, WR_EN, CALL_EN, EXC_EN, EXC_RETURN_EN, STATUS_WR_EN, PC_LOAD_EN} = '0;
        {XFER_EN, PSEL, PENABLE, PWRITE, slow, RD_A_NUM, RD_B_NUM, WR_NUM, XFER_ADDR, PADDR} = '0;
        {WR_DATA, CALL_RETURN, EXC_RETURN, EXC_VECTOR, STATUS_WR_DATA, PC_LOAD, PWDATA} = '0;
        CLK_EN = 1'b1;
        EXC_MODE = MODE_USER;
        XFER_SIZE = SIZE_BYTE;
        repeat (6) @(posedge CLOCK);
        ARST_N <= 1'b1;
        @(posedge CLOCK);
        chk(STATUS, SW_RESET);
        chk({31'h0, PRIVILEGED}, 32'h1);
        v = $random(seed);
        wb(4'h1, v);
        do @(posedge CLOCK); while (STAGE != STG_FETCH);
        WR_EN <= 1'b1;
        WR_DATA <= ~v;
        @(posedge CLOCK);
        WR_EN <= 1'b0;
        rd(8'h44, v);
        for (i = 0; i < 7; i++)
        begin
            slow <= i[0];
            set_sw({24'h0, 3'h6, modes[i]});
            chk(STATUS, {24'h0, 3'h6, modes[i]});
            chk({31'h0, PRIVILEGED}, {31'h0, modes[i] != MODE_USER});
            v = $random(seed);
            wb(REG_STACK, v);
            rd(8'h40 + {1'b0, sp_slot[i], 2'b0}, v);
            wb(REG_FAST_FIRST, ~v);
            rd(i == 1 ? 8'h80 : 8'h60, ~v);
        end
        set_sw(32'hD1);
        wb(4'h0, v);
        set_sw(32'hD0);
        RD_A_NUM <= 4'h0;
        PC_LOAD <= ~v;
        RD_B_NUM <= REG_PC;
        hit(4'h1);
        chk(RD_A_DATA, v);
        chk(RD_B_DATA, ~v);
        set_sw(32'hD2);
        CALL_RETURN <= v;
        hit(4'h8);
        rd(8'hA0, v);
        set_sw(32'hA0000030);
        chk({31'h0, COMPACT}, 32'h1);
        EXC_MODE <= MODE_FAST;
        EXC_RETURN <= v;
        EXC_VECTOR <= ~v;
        hit(4'h4);
        chk(STATUS, 32'hA00000D1);
        rd(ADDR_SAVED, 32'hA0000030);
        rd(8'h98, v);
        rd(ADDR_PC, ~v);
        hit(4'h2);
        chk(STATUS, 32'hA0000030);
        rd(ADDR_PC, v);
        EXC_MODE <= MODE_USER;
        hit(4'h4);
        chk(STATUS, 32'hA0000093);
        rd(ADDR_SAVED, 32'hA0000030);
        set_sw(32'hFFFFFFFF);
        chk(STATUS, 32'hF00000FF);
        set_sw(32'h0);
        chk(STATUS, 32'h10);
        apb(1'b1, ADDR_STATUS, 32'h1F, err);
        rd(ADDR_STATUS, 32'h1F);
        apb(1'b1, 8'h20, 32'h0, err);
        chk({31'h0, err}, 32'h1);
        XFER_EN <= 1'b1;
        for (i = 0; i < 12; i++)
        begin
            XFER_SIZE <= size_t_t'(i / 4);
            XFER_ADDR <= i[1:0];
            repeat (2) @(posedge CLOCK);
            chk({31'h0, MISALIGNED}, {31'h0, (i >= 8 && i[1:0] != 0) || (i / 4 == 1 && i[0])});
        end
        XFER_EN <= 1'b0;
        // Clock enable low must swallow a status write
        CLK_EN <= 1'b0;
        set_sw(32'h13);
        chk(STATUS, 32'h1F);
        CLK_EN <= 1'b1;
        repeat (4) @(posedge CLOCK);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
